//--- shared/lpm_pkg.sv
// Constants, field layouts and carrier types of the low-power mode control.
package lpm_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register byte offsets on the APB.
    localparam logic [11:0] OFF_STATUS_WORD  = 12'h000;
    localparam logic [11:0] OFF_CLK_CFG      = 12'h004;
    localparam logic [11:0] OFF_STATE        = 12'h008;
    localparam logic [11:0] OFF_RESET_VECTOR = 12'h00c;
    localparam logic [11:0] OFF_IO_LOCK      = 12'h010;

    // Field positions in the read-only state register.
    localparam int ST_EN_LSB     = 0;
    localparam int ST_MODE_LSB   = 16;
    localparam int ST_FREEZE_BIT = 24;
    localparam int ST_OFF_BIT    = 25;

    // Write one here to release the frozen pins.
    localparam int IO_UNLOCK_BIT = 0;

    // Mode-control bits, most significant first as they sit in the word.
    typedef struct packed {
        logic clock_gen_off_hi;
        logic clock_gen_off_lo;
        logic crystal_osc_disable;
        logic core_halt;
    } lpm_mode_bits_t;

    typedef struct packed {
        logic rtc_config_ok;
        logic rtc_select;
        logic dco_src_sub;
        logic dco_src_aux;
        logic dco_src_main;
        logic regulator_shutdown;
        logic sub_clock_disable;
    } lpm_cfg_t;

    typedef struct packed {
        logic rtc_run;
        logic mem_retain;
        logic regulator_en;
        logic fll_en;
        logic dco_bias_en;
        logic dco_en;
        logic sub_clk_en;
        logic aux_clk_en;
        logic main_clk_en;
        logic core_run;
    } lpm_enables_t;

    typedef enum logic [3:0] {
        LPM_ACTIVE,
        LPM_SLEEP_0,
        LPM_SLEEP_1,
        LPM_SLEEP_2,
        LPM_SLEEP_3,
        LPM_SLEEP_4,
        LPM_OTHER,
        LPM_DEEP_RTC,
        LPM_DEEP_OFF
    } lpm_mode_t;

    // Mode-bit encodings, clock_gen_off_hi first.
    localparam logic [3:0] ENC_ACTIVE  = 4'h0;
    localparam logic [3:0] ENC_SLEEP_0 = 4'h1;
    localparam logic [3:0] ENC_SLEEP_1 = 4'h5;
    localparam logic [3:0] ENC_SLEEP_2 = 4'h9;
    localparam logic [3:0] ENC_SLEEP_3 = 4'hd;
    localparam logic [3:0] ENC_SLEEP_4 = 4'hf;

    localparam lpm_mode_bits_t STATUS_RESET = 4'h0;
    // Main, auxiliary and sub-main clocks all drawn from the oscillator.
    localparam lpm_cfg_t       CFG_RESET    = 7'h1c;

    localparam logic [7:0] RSTVEC_NONE     = 8'h00;
    localparam logic [7:0] RSTVEC_CORE_OFF = 8'h08;

endpackage

//--- hdl/lpm_ctrl.sv
// Low-power operating-mode controller with its APB register file.
//
// Notes on behaviour
// - Mode comes from the four status-word bits with the listed encodings.
// - Active mode keeps the core, main clock and auxiliary clock running.
// - Sub-main clock runs in active, sleep 0 and 1 only when not disabled.
// - Active: oscillator on if it feeds auxiliary, main or running sub-main.
// - Sleep 0 to 4 and both deep modes stop the core and the main clock.
// - Sleep 0 and 1: oscillator on only if it feeds auxiliary or sub-main.
// - Bias on with oscillator, or in active, sleep 0 and 1 when it feeds main or sub-main clock.
// - Loop runs with oscillator in active and sleep 0; off in 1 to 3.
// - Sleep 2 and 3 keep auxiliary clock, sub-main clock is off.
// - Sleep 2 and 3: oscillator on only if it feeds the auxiliary clock.
// - Sleep 4 stops the core and every clock except a configured rtc.
// - A newly written mode takes effect at once.
// - Peripherals stay idle while their clock is gated.
// - Sleep 0 to 4 retain pins, memory and registers.
// - Any enabled interrupt wakes the device from sleep 0 to 4.
// - Entry pushes the status word; return restores the popped value.
// - All mode bits set with regulator shutdown cuts the core regulator.
// - Deep off runs no clock; deep rtc may keep a configured rtc.
// - Entering core-off freezes every pin state.
// - Core-off ends only on power sequence, reset pin or pin wake.
// - Core-off exit raises brownout reset and reset vector reads 08h.
// - Interrupt entry clears halt, high clock-gen and crystal bits.

`timescale 1ns/1ps

module lpm_ctrl (
    // Clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [lpm_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [lpm_pkg::DATA_W-1:0]  pwdata,
    output logic      [lpm_pkg::DATA_W-1:0]  prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Processor core interrupt side
    input  wire logic                        irq_request,
    input  wire logic                        irq_return,
    input  wire lpm_pkg::lpm_mode_bits_t     return_word,
    output lpm_pkg::lpm_mode_bits_t          stack_word,
    output logic                             stack_strobe,
    output lpm_pkg::lpm_mode_bits_t          status_word,
    // Core-off wake sources
    input  wire logic                        power_cycle,
    input  wire logic                        reset_pin_event,
    input  wire logic                        io_wake,
    // Clock, power and pin control
    output lpm_pkg::lpm_enables_t            clk_en,
    output lpm_pkg::lpm_mode_t               mode,
    output logic                             io_freeze,
    output logic                             brownout_reset
);

    typedef enum logic [1:0] {
        ST_RUN,
        ST_CORE_OFF,
        ST_BOR
    } lpm_state_t;

    lpm_state_t              state;
    lpm_state_t              next_state;
    lpm_pkg::lpm_cfg_t       cfg;
    lpm_pkg::lpm_cfg_t       next_cfg;
    lpm_pkg::lpm_mode_bits_t next_status;
    lpm_pkg::lpm_mode_bits_t pre_entry;
    logic [7:0]              reset_vector;
    logic [lpm_pkg::DATA_W-1:0] rd_mux;
    logic                    setup;
    logic                    done;
    logic                    wr_status;
    logic                    wr_cfg;
    logic                    wr_lock;
    logic                    rd_rstvec;
    logic                    take_irq;

    function automatic logic lpm_hit(input logic [lpm_pkg::ADDR_W-1:0] a);
        lpm_hit = (a == lpm_pkg::OFF_STATUS_WORD) ||
                  (a == lpm_pkg::OFF_CLK_CFG) ||
                  (a == lpm_pkg::OFF_STATE) ||
                  (a == lpm_pkg::OFF_RESET_VECTOR) ||
                  (a == lpm_pkg::OFF_IO_LOCK);
    endfunction

    // Encodings outside the table still get a consistent decode, since the
    // enable equations are written per bit rather than per named mode.
    function automatic lpm_pkg::lpm_enables_t lpm_decode(
        input lpm_pkg::lpm_mode_bits_t b,
        input lpm_pkg::lpm_cfg_t       c,
        input logic                    core_off
    );
        lpm_pkg::lpm_enables_t e;
        e = '0;
        e.core_run    = !b.core_halt;
        e.main_clk_en = !b.core_halt;
        e.aux_clk_en  = !b.crystal_osc_disable;
        // Gated clocks hold their peripherals idle until they run again.
        e.sub_clk_en  = !b.clock_gen_off_hi && !b.crystal_osc_disable &&
                        !c.sub_clock_disable;
        e.dco_en      = (c.dco_src_aux && e.aux_clk_en) ||
                        (c.dco_src_main && e.main_clk_en) ||
                        (c.dco_src_sub && e.sub_clk_en);
        e.dco_bias_en = e.dco_en ||
                        (!b.clock_gen_off_hi && !b.crystal_osc_disable &&
                         (c.dco_src_main ||
                          (c.dco_src_sub && e.sub_clk_en)));
        e.fll_en      = e.dco_en && !b.clock_gen_off_lo &&
                        !b.clock_gen_off_hi;
        e.regulator_en = 1'b1;
        e.mem_retain   = 1'b1;
        e.rtc_run      = c.rtc_config_ok;
        if (core_off) begin
            e = '0;
            e.rtc_run = c.rtc_select && c.rtc_config_ok;
        end
        lpm_decode = e;
    endfunction

    function automatic lpm_pkg::lpm_mode_t lpm_mode_of(
        input lpm_pkg::lpm_mode_bits_t b,
        input logic                    core_off,
        input logic                    rtc_sel
    );
        lpm_pkg::lpm_mode_t m;
        m = lpm_pkg::LPM_OTHER;
        if (core_off) begin
            m = rtc_sel ? lpm_pkg::LPM_DEEP_RTC : lpm_pkg::LPM_DEEP_OFF;
        end else if (b == lpm_pkg::ENC_ACTIVE) begin
            m = lpm_pkg::LPM_ACTIVE;
        end else if (b == lpm_pkg::ENC_SLEEP_0) begin
            m = lpm_pkg::LPM_SLEEP_0;
        end else if (b == lpm_pkg::ENC_SLEEP_1) begin
            m = lpm_pkg::LPM_SLEEP_1;
        end else if (b == lpm_pkg::ENC_SLEEP_2) begin
            m = lpm_pkg::LPM_SLEEP_2;
        end else if (b == lpm_pkg::ENC_SLEEP_3) begin
            m = lpm_pkg::LPM_SLEEP_3;
        end else if (b == lpm_pkg::ENC_SLEEP_4) begin
            m = lpm_pkg::LPM_SLEEP_4;
        end
        lpm_mode_of = m;
    endfunction

    // No wait state: data and error are registered in the setup cycle.
    assign setup = psel && !penable;
    assign done  = psel && penable && pready;

    always_comb begin
        wr_status = 1'b0;
        wr_cfg    = 1'b0;
        wr_lock   = 1'b0;
        rd_rstvec = 1'b0;
        if (done && !pslverr) begin
            if (paddr == lpm_pkg::OFF_STATUS_WORD) begin
                wr_status = pwrite;
            end else if (paddr == lpm_pkg::OFF_CLK_CFG) begin
                wr_cfg = pwrite;
            end else if (paddr == lpm_pkg::OFF_RESET_VECTOR) begin
                rd_rstvec = !pwrite;
            end else if (paddr == lpm_pkg::OFF_IO_LOCK) begin
                wr_lock = pwrite;
            end
        end
    end

    always_comb begin
        rd_mux = '0;
        if (paddr == lpm_pkg::OFF_STATUS_WORD) begin
            rd_mux[3:0] = status_word;
        end else if (paddr == lpm_pkg::OFF_CLK_CFG) begin
            rd_mux[6:0] = cfg;
        end else if (paddr == lpm_pkg::OFF_STATE) begin
            rd_mux[lpm_pkg::ST_EN_LSB +: 10] = clk_en;
            rd_mux[lpm_pkg::ST_MODE_LSB +: 4] = mode;
            rd_mux[lpm_pkg::ST_FREEZE_BIT] = io_freeze;
            rd_mux[lpm_pkg::ST_OFF_BIT] = (state == ST_CORE_OFF);
        end else if (paddr == lpm_pkg::OFF_RESET_VECTOR) begin
            rd_mux[7:0] = reset_vector;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !lpm_hit(paddr);
            prdata  <= (setup && !pwrite) ? rd_mux : '0;
        end
    end

    // Interrupts are not taken while the core supply is cut.
    assign take_irq = irq_request && (state == ST_RUN);

    always_comb begin
        pre_entry = status_word;
        if (state == ST_BOR) begin
            pre_entry = lpm_pkg::STATUS_RESET;
        end else if (state == ST_RUN && irq_return) begin
            pre_entry = return_word;
        end else if (state == ST_RUN && wr_status) begin
            pre_entry = pwdata[3:0];
        end
        next_status = pre_entry;
        if (take_irq) begin
            next_status.core_halt           = 1'b0;
            next_status.clock_gen_off_hi    = 1'b0;
            next_status.crystal_osc_disable = 1'b0;
        end
    end

    always_comb begin
        next_cfg = cfg;
        if (state == ST_BOR) begin
            // The rtc keeps its setup so that it runs on through the wake.
            next_cfg = lpm_pkg::CFG_RESET;
            next_cfg.rtc_select    = cfg.rtc_select;
            next_cfg.rtc_config_ok = cfg.rtc_config_ok;
        end else if (wr_cfg && state == ST_RUN) begin
            next_cfg = pwdata[6:0];
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if ((&next_status) && next_cfg.regulator_shutdown) begin
                    next_state = ST_CORE_OFF;
                end
            end
            ST_CORE_OFF: begin
                if (power_cycle || reset_pin_event || io_wake) begin
                    next_state = ST_BOR;
                end
            end
            ST_BOR: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_word <= lpm_pkg::STATUS_RESET;
            cfg         <= lpm_pkg::CFG_RESET;
        end else begin
            status_word <= next_status;
            cfg         <= next_cfg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_word   <= lpm_pkg::STATUS_RESET;
            stack_strobe <= 1'b0;
        end else begin
            stack_strobe <= take_irq;
            if (take_irq) begin
                stack_word <= pre_entry;
            end
        end
    end

    // Decoding from the next value lets the enables move on the write edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_en <= lpm_decode(lpm_pkg::STATUS_RESET, lpm_pkg::CFG_RESET,
                                 1'b0);
            mode   <= lpm_pkg::LPM_ACTIVE;
        end else begin
            clk_en <= lpm_decode(next_status, next_cfg,
                                 next_state == ST_CORE_OFF);
            mode   <= lpm_mode_of(next_status, next_state == ST_CORE_OFF,
                                  next_cfg.rtc_select);
        end
    end

    // Pins stay frozen through the wake until software releases them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_freeze <= 1'b0;
        end else if (next_state == ST_CORE_OFF) begin
            io_freeze <= 1'b1;
        end else if (wr_lock && pwdata[lpm_pkg::IO_UNLOCK_BIT]) begin
            io_freeze <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_reset <= 1'b0;
        end else begin
            brownout_reset <= (next_state == ST_BOR);
        end
    end

    // A new core-off exit wins over a read that clears the vector.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_vector <= lpm_pkg::RSTVEC_NONE;
        end else if (next_state == ST_BOR) begin
            reset_vector <= lpm_pkg::RSTVEC_CORE_OFF;
        end else if (rd_rstvec) begin
            reset_vector <= lpm_pkg::RSTVEC_NONE;
        end
    end

endmodule

//--- verif/lpm_ctrl_asserts.sv
// Port checker for the low-power mode controller, bound to its top.
`timescale 1ns/1ps
module lpm_ctrl_asserts (
    // Clock, reset and bus handshake
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pready,
    input wire logic                    pslverr,
    // Core, wake and control side
    input wire logic                    irq_request,
    input wire logic                    stack_strobe,
    input wire lpm_pkg::lpm_mode_bits_t status_word,
    input wire logic                    power_cycle,
    input wire logic                    reset_pin_event,
    input wire logic                    io_wake,
    input wire lpm_pkg::lpm_enables_t   clk_en,
    input wire lpm_pkg::lpm_mode_t      mode,
    input wire logic                    io_freeze,
    input wire logic                    brownout_reset
);
    logic deep;
    assign deep = mode inside {lpm_pkg::LPM_DEEP_RTC, lpm_pkg::LPM_DEEP_OFF};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property (psel && !penable |=>
        pready && !$past(penable))
        else $error("pready not one cycle after setup");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_active_run: assert property (status_word == 4'h0 |->
        clk_en.core_run && clk_en.main_clk_en && clk_en.aux_clk_en)
        else $error("active mode lacks core or clocks");
    a_sleep_stop: assert property (
        status_word inside {4'h1, 4'h5, 4'h9, 4'hd, 4'hf} |->
        !clk_en.core_run && !clk_en.main_clk_en)
        else $error("core or main clock runs in sleep");
    a_all_off: assert property (status_word == 4'hf |->
        clk_en[6:0] == 7'h00) else $error("clock runs in deepest sleep");
    a_sub_off: assert property (status_word inside {4'h9, 4'hd} |->
        clk_en.aux_clk_en && !clk_en.sub_clk_en && !clk_en.fll_en)
        else $error("wrong clocks in sleep 2 or 3");
    a_loop_osc: assert property (clk_en.fll_en |-> clk_en.dco_en)
        else $error("loop runs without oscillator");
    a_bias_osc: assert property (clk_en.dco_en |-> clk_en.dco_bias_en)
        else $error("oscillator on without bias");
    a_mode_dec: assert property (status_word == 4'h9 |->
        mode == lpm_pkg::LPM_SLEEP_2) else $error("mode decode wrong");
    a_entry_clr: assert property (
        irq_request && !brownout_reset && !deep |=> stack_strobe &&
        !status_word.clock_gen_off_hi && !status_word.crystal_osc_disable &&
        !status_word.core_halt && clk_en.core_run)
        else $error("entry did not clear mode bits");
    a_off_frz: assert property (deep |-> io_freeze &&
        !clk_en.regulator_en && !clk_en.mem_retain)
        else $error("core-off without freeze or with regulator");
    a_off_stay: assert property (deep && !power_cycle && !reset_pin_event
        && !io_wake |=> deep) else $error("core-off left without wake");
    a_brownout_pulse: assert property (brownout_reset |=>
        !brownout_reset && status_word == 4'h0)
        else $error("brownout pulse wrong");
    c_deep: cover property (deep ##1 brownout_reset);
    c_irq: cover property (stack_strobe);
    c_err: cover property (pslverr);
endmodule
bind lpm_ctrl lpm_ctrl_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .irq_request(irq_request), .stack_strobe(stack_strobe),
    .status_word(status_word), .power_cycle(power_cycle),
    .reset_pin_event(reset_pin_event), .io_wake(io_wake), .clk_en(clk_en),
    .mode(mode), .io_freeze(io_freeze), .brownout_reset(brownout_reset));

//--- verif/lpm_core_model.sv
// Behavioural processor core that takes interrupts and returns from them.
`timescale 1ns/1ps
module lpm_core_model (
    // Clock
    input wire logic                     pclk,
    // Interrupt side of the controller
    output logic                         irq_request,
    output logic                         irq_return,
    output lpm_pkg::lpm_mode_bits_t      return_word,
    input  wire lpm_pkg::lpm_mode_bits_t stack_word,
    input  wire logic                    stack_strobe
);
    lpm_pkg::lpm_mode_bits_t saved;
    initial begin
        irq_request = 1'b0;
        irq_return = 1'b0;
        return_word = 4'h0;
        saved = 4'h0;
    end
    always @(posedge pclk) begin
        if (stack_strobe) begin
            saved <= stack_word;
        end
    end
    task take_irq();
        @(posedge pclk);
        irq_request <= 1'b1;
        @(posedge pclk);
        irq_request <= 1'b0;
    endtask
    // Two edges first, so the pushed word has surely been captured.
    task give_return(input logic alter, input logic [3:0] w);
        repeat (2) @(posedge pclk);
        irq_return <= 1'b1;
        return_word <= alter ? w : saved;
        @(posedge pclk);
        irq_return <= 1'b0;
        return_word <= ~return_word;
    endtask
endmodule

//--- verif/lpm_ctrl_tb.sv
// Self-checking testbench of the low-power mode controller.
`timescale 1ns/1ps
module lpm_ctrl_tb;
    logic                    pclk, presetn, psel, penable, pwrite;
    logic [11:0]             paddr;
    logic [31:0]             pwdata, prdata, rd;
    logic                    pready, pslverr, err, irq_request, irq_return;
    lpm_pkg::lpm_mode_bits_t return_word, stack_word, status_word;
    logic                    stack_strobe, io_freeze, brownout_reset;
    logic                    power_cycle, reset_pin_event, io_wake;
    lpm_pkg::lpm_enables_t   clk_en;
    lpm_pkg::lpm_mode_t      mode;
    int                      miscompares, comparisons;
    logic [3:0]              m_sw;
    logic [6:0]              m_cfg;
    logic                    m_off, m_frz;
    logic [3:0]              encs[$] = '{4'h0, 4'h1, 4'h5, 4'h9, 4'hd, 4'hf};
    lpm_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_request(irq_request), .irq_return(irq_return),
        .return_word(return_word), .stack_word(stack_word),
        .stack_strobe(stack_strobe), .status_word(status_word),
        .power_cycle(power_cycle), .reset_pin_event(reset_pin_event),
        .io_wake(io_wake), .clk_en(clk_en), .mode(mode),
        .io_freeze(io_freeze), .brownout_reset(brownout_reset));
    lpm_core_model u_core (.pclk(pclk), .irq_request(irq_request),
        .irq_return(irq_return), .return_word(return_word),
        .stack_word(stack_word), .stack_strobe(stack_strobe));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Config bits: 6 rtc ok, 5 rtc select, 4..2 oscillator feeds sub,
    // aux, main, 1 regulator shutdown, 0 sub-main clock disable.
    function automatic logic [9:0] exp_en(logic [3:0] s, logic [6:0] c);
        logic act, s01, sub, aux, digital_ctrl_osc, bias, freq_lock_loop;
        if (s == 4'hf && c[1]) return {c[6] & c[5], 9'h000};
        // The core runs whenever halt is clear, also inside a handler where
        // entry has left only the low clock-gen bit set.
        act = !s[0];
        s01 = s == 4'h1 || s == 4'h5;
        sub = (act || s01) && !c[0];
        aux = s != 4'hf;
        digital_ctrl_osc = c[3] && aux || c[4] && sub || c[2] && act;
        bias = digital_ctrl_osc || (act || s01) && (c[2] || c[4] && sub);
        freq_lock_loop = digital_ctrl_osc && (s == 4'h0 || s == 4'h1);
        return {c[6], 2'b11, freq_lock_loop, bias, digital_ctrl_osc, sub, aux, act, act};
    endfunction
    function automatic logic [3:0] exp_mode(logic [3:0] s, logic [6:0] c);
        if (s == 4'hf && c[1]) return c[5] ? 4'h7 : 4'h8;
        for (int i = 0; i < 6; i++) if (encs[i] == s) return i[3:0];
        return 4'h6;
    endfunction
    function automatic logic [31:0] exp_state();
        return {6'h00, m_off, m_frz, 4'h0, exp_mode(m_sw, m_cfg), 6'h00,
            exp_en(m_sw, m_cfg)};
    endfunction
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_ports();
        @(negedge pclk);
        chk("status_word", {28'h0, m_sw}, {28'h0, status_word});
        chk("clk_en", {22'h0, exp_en(m_sw, m_cfg)}, {22'h0, clk_en});
        chk("mode", {28'h0, exp_mode(m_sw, m_cfg)}, {28'h0, mode});
        chk("io_freeze", {31'h0, m_frz}, {31'h0, io_freeze});
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Writes to the mode or config register are dropped while core-off.
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (!m_off && a == 12'h000) m_sw = d[3:0];
        if (!m_off && a == 12'h004) m_cfg = d[6:0];
        if (a == 12'h010 && d[0]) m_frz = 1'b0;
        if (m_sw == 4'hf && m_cfg[1]) {m_off, m_frz} = 2'b11;
        chk_ports();
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("prdata", e, rd);
    endtask
    task print_verdict();
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        logic [6:0] c;
        logic [3:0] s;
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {power_cycle, reset_pin_event, io_wake} = 3'b000;
        {m_sw, m_cfg, m_off, m_frz} = {4'h0, 7'h1c, 2'b00};
        void'($urandom(32'h3a3e));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(12'h004, 32'h1c);
        rdchk(12'h008, exp_state());
        rdchk(12'h014, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        for (int i = 0; i < 40; i++) begin
            c = 7'($urandom);
            c[1] = 1'b0;
            wr(12'h004, {25'h0, c});
            wr(12'h000, {28'h0, encs[$urandom_range(5)]});
            rdchk(12'h008, exp_state());
        end
        for (int i = 1; i < 6; i++) begin
            wr(12'h000, {28'h0, encs[i]});
            u_core.take_irq();
            s = m_sw;
            m_sw = m_sw & 4'h4;
            chk_ports();
            chk("stack_word", {28'h0, s}, {28'h0, stack_word});
            chk("stack_strobe", 32'h1, {31'h0, stack_strobe});
            m_sw = i[0] ? encs[i - 1] : s;
            u_core.give_return(i[0], encs[i - 1]);
            chk_ports();
        end
        for (int k = 0; k < 3; k++) begin
            wr(12'h000, 32'h0);
            wr(12'h004, {25'h0, 1'b1, k == 0, 5'h1e});
            wr(12'h000, 32'hf);
            u_core.take_irq();
            wr(12'h000, 32'h0);
            @(posedge pclk);
            {power_cycle, reset_pin_event, io_wake} <= 3'b001 << k;
            @(posedge pclk);
            {power_cycle, reset_pin_event, io_wake} <= 3'b000;
            {m_sw, m_cfg, m_off} = {4'h0, m_cfg[6:5], 5'h1c, 1'b0};
            // The reset values reach the ports one cycle after the pulse.
            @(negedge pclk);
            chk("brownout_reset", 32'h1, {31'h0, brownout_reset});
            chk_ports();
            rdchk(12'h00c, 32'h08);
            rdchk(12'h00c, 32'h00);
            wr(12'h010, 32'h1);
        end
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        print_verdict();
    end
endmodule
